// ===== verilog/usf_regs.svh
// Register offsets, field positions, reset values and counts of the serial status flag block
// Function
// - Flags clear by status read, then data access
// - Writes to status register are ignored
// - Buffer empty sets on shifter take, clears
// - Complete low while sending, high when idle
// - Complete clears by sequence or queueing; clear wins
// - Receive full sets on frame transfer, clears
// - Idle sets after 10 or 11 ones
// - Idle rearms only after receive full sets
// - Wakeup bit blocks idle flag setting
// - Idle clears by status then data read
// - Overrun sets on unread frame, discards data
// - Overrun needs status-seen then data read
// - Noise sets with receive full, not overrun
// - Framing error sets, blocks reception until cleared
// - Parity error sets on mismatch when enabled
// - Wakeup bit blocks receive requests, hardware clears
// - Receive interrupt enable gates full or overrun request
`ifndef USF_REGS_SVH
`define USF_REGS_SVH
`define USF_CTRL_OFF       4'h0
`define USF_STATUS_OFF     4'h4
`define USF_DATA_OFF       4'h8
`define USF_BIT_TX_EMPTY   7
`define USF_BIT_TX_DONE    6
`define USF_BIT_RX_FULL    5
`define USF_BIT_IDLE       4
`define USF_BIT_OR         3
`define USF_BIT_NOISE      2
`define USF_BIT_FRAME_ERR  1
`define USF_BIT_PAR_ERR    0
`define USF_CTL_PAR_EN     0
`define USF_CTL_PAR_ODD    1
`define USF_CTL_NINE_BIT   2
`define USF_CTL_RX_IE      3
`define USF_CTL_WAKEUP     4
`define USF_CTRL_RESET     5'h00
`define USF_STATUS_RESET   8'hC0
`define USF_IDLE_ONES_8    4'hA
`define USF_IDLE_ONES_9    4'hB
`endif

// ===== verilog/usf_pkg.sv
// Types shared by the serial status flag block
`default_nettype none
package usf_pkg;
    typedef logic [7:0] usf_flags_t;
    typedef enum logic [1:0]
    {
        USF_ACC_NONE    = 2'b00,
        USF_ACC_STAT_RD = 2'b01,
        USF_ACC_DATA_RD = 2'b10,
        USF_ACC_DATA_WR = 2'b11
    } usf_acc_t;
endpackage : usf_pkg
`default_nettype wire

// ===== verilog/usf_status_flags.sv
// Status flag logic, Wishbone register slave and transmit buffer of the serial interface
//
// The Wishbone register port was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "usf_regs.svh"
module usf_status_flags #(
    parameter int DATA_W = 8
) (
    input  wire logic              MCLK,
    input  wire logic              SYS_RST,
    input  wire logic              WB_CYC_I,
    input  wire logic              WB_STB_I,
    input  wire logic              WB_WE_I,
    input  wire logic [3:0]        WB_ADR_I,
    input  wire logic [3:0]        WB_SEL_I,
    input  wire logic [31:0]       WB_DAT_I,
    output logic      [31:0]       WB_DAT_O,
    output logic                   WB_ACK_O,
    output logic      [DATA_W-1:0] TX_DATA,
    output logic                   TX_VALID,
    input  wire logic              TX_READY,
    input  wire logic              TX_BUSY,
    input  wire logic              TX_QUEUE,
    input  wire logic              RX_FRAME_DONE,
    input  wire logic [DATA_W-1:0] RX_DATA,
    input  wire logic              RX_PARITY_BIT,
    input  wire logic              RX_NOISE,
    input  wire logic              RX_STOP_ZERO,
    input  wire logic              RX_BIT_TICK,
    input  wire logic              RX_IN,
    input  wire logic              RX_WAKE,
    output logic                   RX_BLOCK,
    output logic                   RX_IRQ_REQ
);

    ////////////////////////////////////////////////////////////////////////////////
    // Bus decode

    function automatic usf_pkg::usf_acc_t acc_decode(input logic       we,
                                                     input logic [3:0] adr);
        acc_decode = usf_pkg::USF_ACC_NONE;
        if (adr == `USF_STATUS_OFF && !we)
        begin
            acc_decode = usf_pkg::USF_ACC_STAT_RD;
        end
        else if (adr == `USF_DATA_OFF)
        begin
            acc_decode = we ? usf_pkg::USF_ACC_DATA_WR : usf_pkg::USF_ACC_DATA_RD;
        end
    endfunction : acc_decode

    logic                 ack_r;
    logic [31:0]          rdata_r;
    logic [4:0]           ctrl_r;
    usf_pkg::usf_flags_t  flags_r;
    usf_pkg::usf_flags_t  armed_r;
    logic [DATA_W-1:0]    rx_data_r;
    logic [DATA_W-1:0]    head_r;
    logic [DATA_W-1:0]    tail_r;
    logic                 head_v_r;
    logic                 tail_v_r;
    logic                 idle_ok_r;
    logic [3:0]           ones_r;
    logic                 irq_r;
    logic                 req;
    logic                 take;
    logic                 push;
    logic                 pop;
    logic                 stat_rd;
    logic                 data_rd;
    logic                 data_wr;
    logic                 rx_accept;
    logic                 rx_overrun;
    logic                 idle_hit;
    logic                 par_bad;
    logic [3:0]           idle_need;
    usf_pkg::usf_acc_t    acc;

    assign req  = WB_CYC_I && WB_STB_I && !ack_r;
    assign acc  = acc_decode(WB_WE_I, WB_ADR_I);
    // A data write waits while both buffer entries are held, so no word is lost
    assign take = req && !(acc == usf_pkg::USF_ACC_DATA_WR && tail_v_r);
    assign stat_rd = take && acc == usf_pkg::USF_ACC_STAT_RD;
    assign data_rd = take && acc == usf_pkg::USF_ACC_DATA_RD;
    assign data_wr = take && acc == usf_pkg::USF_ACC_DATA_WR;
    assign push    = data_wr && WB_SEL_I[0];
    assign pop     = head_v_r && TX_READY;

    always_ff @(posedge MCLK)
    begin
        if (SYS_RST)
        begin
            ack_r <= 1'b0;
        end
        else
        begin
            ack_r <= take;
        end
    end

    always_ff @(posedge MCLK)
    begin
        if (SYS_RST)
        begin
            rdata_r <= 32'h0000_0000;
        end
        else if (take && !WB_WE_I)
        begin
            case (acc)
                usf_pkg::USF_ACC_STAT_RD: rdata_r <= {24'h00_0000, flags_r};
                usf_pkg::USF_ACC_DATA_RD: rdata_r <= {{(32-DATA_W){1'b0}}, rx_data_r};
                default: rdata_r <= (WB_ADR_I == `USF_CTRL_OFF) ? {27'h000_0000, ctrl_r} : 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Control register; the wakeup bit is also dropped by the receiver

    always_ff @(posedge MCLK)
    begin
        if (SYS_RST)
        begin
            ctrl_r <= `USF_CTRL_RESET;
        end
        else if (take && WB_WE_I && WB_ADR_I == `USF_CTRL_OFF && WB_SEL_I[0])
        begin
            ctrl_r <= WB_DAT_I[4:0];
        end
        else if (RX_WAKE)
        begin
            ctrl_r[`USF_CTL_WAKEUP] <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Two-entry transmit buffer; head is what the shifter sees

    always_ff @(posedge MCLK)
    begin
        if (SYS_RST)
        begin
            head_v_r <= 1'b0;
            tail_v_r <= 1'b0;
            head_r   <= '0;
            tail_r   <= '0;
        end
        else if (pop)
        begin
            head_v_r <= tail_v_r || push;
            tail_v_r <= tail_v_r && push;
            if (tail_v_r)
            begin
                head_r <= tail_r;
            end
            else if (push)
            begin
                head_r <= WB_DAT_I[DATA_W-1:0];
            end
            if (tail_v_r && push)
            begin
                tail_r <= WB_DAT_I[DATA_W-1:0];
            end
        end
        else if (push)
        begin
            if (!head_v_r)
            begin
                head_r   <= WB_DAT_I[DATA_W-1:0];
                head_v_r <= 1'b1;
            end
            else
            begin
                tail_r   <= WB_DAT_I[DATA_W-1:0];
                tail_v_r <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Receive side events

    // Reception stays frozen while a framing error is pending
    assign rx_accept  = RX_FRAME_DONE && !flags_r[`USF_BIT_FRAME_ERR] && !flags_r[`USF_BIT_RX_FULL];
    assign rx_overrun = RX_FRAME_DONE && !flags_r[`USF_BIT_FRAME_ERR] && flags_r[`USF_BIT_RX_FULL];
    assign par_bad    = ctrl_r[`USF_CTL_PAR_EN] && ((^RX_DATA ^ RX_PARITY_BIT) != ctrl_r[`USF_CTL_PAR_ODD]);
    assign idle_need  = ctrl_r[`USF_CTL_NINE_BIT] ? `USF_IDLE_ONES_9 : `USF_IDLE_ONES_8;
    assign idle_hit   = RX_BIT_TICK && RX_IN && (ones_r + 4'h1 == idle_need);

    always_ff @(posedge MCLK)
    begin
        if (SYS_RST)
        begin
            rx_data_r <= '0;
        end
        else if (rx_accept)
        begin
            rx_data_r <= RX_DATA;
        end
    end

    always_ff @(posedge MCLK)
    begin
        if (SYS_RST)
        begin
            ones_r <= 4'h0;
        end
        else if (RX_BIT_TICK)
        begin
            if (!RX_IN)
            begin
                ones_r <= 4'h0;
            end
            else if (ones_r != idle_need)
            begin
                ones_r <= ones_r + 4'h1;
            end
        end
    end

    // Idle may report once per received frame; a long idle line reports once
    always_ff @(posedge MCLK)
    begin
        if (SYS_RST)
        begin
            idle_ok_r <= 1'b0;
        end
        else if (rx_accept)
        begin
            idle_ok_r <= 1'b1;
        end
        else if (idle_hit && !ctrl_r[`USF_CTL_WAKEUP])
        begin
            idle_ok_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Clear arming: only flags seen set by the status read may clear

    logic clr_rx;
    logic clr_tx;
    usf_pkg::usf_flags_t clr_mask;
    usf_pkg::usf_flags_t set_mask;

    assign clr_rx = data_rd;
    assign clr_tx = data_wr;

    always_comb
    begin
        clr_mask = 8'h00;
        if (clr_rx)
        begin
            clr_mask = armed_r & 8'h3F;
        end
        if (clr_tx)
        begin
            clr_mask = clr_mask | (armed_r & 8'hC0);
        end
    end

    always_comb
    begin
        set_mask = 8'h00;
        set_mask[`USF_BIT_TX_EMPTY] = pop;
        set_mask[`USF_BIT_RX_FULL] = rx_accept;
        set_mask[`USF_BIT_IDLE] = idle_hit && idle_ok_r && !ctrl_r[`USF_CTL_WAKEUP];
        set_mask[`USF_BIT_OR]   = rx_overrun;
        set_mask[`USF_BIT_NOISE]     = rx_accept && RX_NOISE;
        set_mask[`USF_BIT_FRAME_ERR] = rx_accept && RX_STOP_ZERO;
        set_mask[`USF_BIT_PAR_ERR]   = rx_accept && par_bad;
    end

    always_ff @(posedge MCLK)
    begin
        if (SYS_RST)
        begin
            armed_r <= 8'h00;
        end
        else if (stat_rd)
        begin
            armed_r <= flags_r;
        end
        else
        begin
            armed_r <= armed_r & ~clr_mask;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Flags; writes to the status offset never reach here

    logic done_set;
    logic done_clr;

    assign done_set = flags_r[`USF_BIT_TX_EMPTY] && !TX_BUSY && !head_v_r && !TX_QUEUE;
    assign done_clr = clr_mask[`USF_BIT_TX_DONE] || TX_QUEUE || push || TX_BUSY;

    always_ff @(posedge MCLK)
    begin
        if (SYS_RST)
        begin
            flags_r <= `USF_STATUS_RESET;
        end
        else
        begin
            // Set beats clear everywhere except transmit complete, where clear wins
            flags_r <= (flags_r & ~clr_mask) | set_mask;
            flags_r[`USF_BIT_TX_DONE] <= done_clr ? 1'b0 : (done_set | flags_r[`USF_BIT_TX_DONE]);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Receive request and outputs

    always_ff @(posedge MCLK)
    begin
        if (SYS_RST)
        begin
            irq_r <= 1'b0;
        end
        else
        begin
            irq_r <= ctrl_r[`USF_CTL_RX_IE] && !ctrl_r[`USF_CTL_WAKEUP]
                     && (flags_r[`USF_BIT_RX_FULL] || flags_r[`USF_BIT_OR]);
        end
    end

    assign WB_ACK_O   = ack_r;
    assign WB_DAT_O   = rdata_r;
    assign TX_DATA    = head_r;
    assign TX_VALID   = head_v_r;
    assign RX_BLOCK   = flags_r[`USF_BIT_FRAME_ERR];
    assign RX_IRQ_REQ = irq_r;

endmodule : usf_status_flags
`default_nettype wire

// ===== testbench/usf_checker.sv
// Concurrent checks on the ports of the serial status flag block
`timescale 1ns/10ps
`default_nettype none
module usf_checker #(
    parameter int DATA_W = 8
) (
    input wire logic        MCLK,
    input wire logic        SYS_RST,
    input wire logic        WB_CYC_I,
    input wire logic        WB_STB_I,
    input wire logic        WB_WE_I,
    input wire logic [3:0]  WB_ADR_I,
    input wire logic [31:0] WB_DAT_O,
    input wire logic        WB_ACK_O,
    input wire logic [DATA_W-1:0] TX_DATA,
    input wire logic        TX_VALID,
    input wire logic        TX_READY,
    input wire logic        TX_BUSY,
    input wire logic        RX_FRAME_DONE,
    input wire logic        RX_BLOCK
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (SYS_RST);
    logic stat_rd;
    logic data_rd;
    logic data_wr;
    assign stat_rd = WB_ACK_O && !WB_WE_I && WB_ADR_I == 4'h4;
    assign data_rd = WB_ACK_O && !WB_WE_I && WB_ADR_I == 4'h8;
    assign data_wr = WB_CYC_I && WB_STB_I && WB_WE_I && WB_ADR_I == 4'h8;
    sequence s_req;
        WB_CYC_I && WB_STB_I && !WB_ACK_O;
    endsequence
    ack_once_a: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack held two cycles");
    ack_prompt_a: assert property (s_req ##0 !(WB_WE_I && WB_ADR_I == 4'h8) |=> WB_ACK_O)
        else $error("access not acked next cycle");
    ack_cause_a: assert property ($rose(WB_ACK_O) |-> $past(WB_CYC_I && WB_STB_I))
        else $error("ack without request");
    tx_hold_a: assert property (TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA))
        else $error("offered word changed before take");
    tx_push_a: assert property ($rose(TX_VALID) |-> $past(data_wr))
        else $error("word offered without data write");
    done_busy_a: assert property (stat_rd && $past(TX_BUSY) && $past(TX_BUSY, 2) |-> !WB_DAT_O[6])
        else $error("complete high while shifting");
    blk_set_a: assert property ($rose(RX_BLOCK) |-> $past(RX_FRAME_DONE) || $past(RX_FRAME_DONE, 2))
        else $error("block without frame");
    blk_clr_a: assert property ($fell(RX_BLOCK) |-> data_rd || $past(data_rd))
        else $error("block released without data read");
endmodule : usf_checker
bind usf_status_flags usf_checker #(.DATA_W(DATA_W)) u_chk (
    .MCLK          (MCLK),
    .SYS_RST       (SYS_RST),
    .WB_CYC_I      (WB_CYC_I),
    .WB_STB_I      (WB_STB_I),
    .WB_WE_I       (WB_WE_I),
    .WB_ADR_I      (WB_ADR_I),
    .WB_DAT_O      (WB_DAT_O),
    .WB_ACK_O      (WB_ACK_O),
    .TX_DATA       (TX_DATA),
    .TX_VALID      (TX_VALID),
    .TX_READY      (TX_READY),
    .TX_BUSY       (TX_BUSY),
    .RX_FRAME_DONE (RX_FRAME_DONE),
    .RX_BLOCK      (RX_BLOCK)
);
`default_nettype wire

// ===== testbench/usf_far_model.sv
// Remote serial device taking words from the transmit path
`timescale 1ns/10ps
`default_nettype none
module usf_far_model (
    input  wire logic       MCLK,
    input  wire logic       stall,
    input  wire logic [7:0] TX_DATA,
    input  wire logic       TX_VALID,
    output logic            TX_READY,
    output logic            TX_BUSY
);
    logic [7:0] got[$];
    int         busy_n = 0;
    assign TX_BUSY = busy_n != 0;
    // Slow shifter: no new word until the current frame is out
    always @(posedge MCLK)
    begin
        TX_READY <= !stall && busy_n < 2 && !(TX_VALID && TX_READY);
        if (TX_VALID && TX_READY)
        begin
            got.push_back(TX_DATA);
            busy_n <= 20;
        end
        else if (busy_n != 0)
            busy_n <= busy_n - 1;
    end
endmodule : usf_far_model
`default_nettype wire

// ===== testbench/test_usf_status_flags.sv
// Self-checking bench for the serial status flag block
`timescale 1ns/10ps
`default_nettype none
module test_usf_status_flags;
    logic        MCLK, SYS_RST, WB_CYC_I, WB_STB_I, WB_WE_I, WB_ACK_O, TX_VALID, TX_READY, TX_BUSY;
    logic        TX_QUEUE, RX_FRAME_DONE, RX_PARITY_BIT, RX_NOISE, RX_STOP_ZERO, RX_BIT_TICK, RX_IN;
    logic        RX_WAKE, RX_BLOCK, RX_IRQ_REQ, stall;
    logic [3:0]  WB_ADR_I, WB_SEL_I;
    logic [31:0] WB_DAT_I, WB_DAT_O;
    logic [7:0]  TX_DATA, RX_DATA, rd;
    int          bad_count, compares;
    usf_status_flags u_dut (
        .MCLK          (MCLK),
        .SYS_RST       (SYS_RST),
        .WB_CYC_I      (WB_CYC_I),
        .WB_STB_I      (WB_STB_I),
        .WB_WE_I       (WB_WE_I),
        .WB_ADR_I      (WB_ADR_I),
        .WB_SEL_I      (WB_SEL_I),
        .WB_DAT_I      (WB_DAT_I),
        .WB_DAT_O      (WB_DAT_O),
        .WB_ACK_O      (WB_ACK_O),
        .TX_DATA       (TX_DATA),
        .TX_VALID      (TX_VALID),
        .TX_READY      (TX_READY),
        .TX_BUSY       (TX_BUSY),
        .TX_QUEUE      (TX_QUEUE),
        .RX_FRAME_DONE (RX_FRAME_DONE),
        .RX_DATA       (RX_DATA),
        .RX_PARITY_BIT (RX_PARITY_BIT),
        .RX_NOISE      (RX_NOISE),
        .RX_STOP_ZERO  (RX_STOP_ZERO),
        .RX_BIT_TICK   (RX_BIT_TICK),
        .RX_IN         (RX_IN),
        .RX_WAKE       (RX_WAKE),
        .RX_BLOCK      (RX_BLOCK),
        .RX_IRQ_REQ    (RX_IRQ_REQ)
    );
    usf_far_model u_far (.MCLK, .stall, .TX_DATA, .TX_VALID, .TX_READY, .TX_BUSY);
    ////////////////////////////////////////////////////////////////////////////////
    task final_report;
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : final_report
    task chk(input string n, input logic [7:0] e, input logic [7:0] s);
        compares++;
        if (s !== e)
        begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    // Waits for transmit valid (0) or busy (1) to fall; running out ends the run
    task wt(input logic busy);
        int i;
        for (i = 0; i < 200 && (busy ? TX_BUSY : TX_VALID) !== 1'h0; i++)
            @(posedge MCLK);
        chk("wait", 8'h00, 8'(busy ? TX_BUSY : TX_VALID));
        if (i == 200)
            final_report();
    endtask : wt
    task wb(input logic we, input logic [3:0] a, input logic [7:0] d);
        int i;
        {WB_CYC_I, WB_STB_I, WB_WE_I, WB_ADR_I} <= {2'h3, we, a};
        WB_DAT_I <= 32'(d);
        for (i = 0; i < 60 && WB_ACK_O !== 1'h1; i++)
            @(posedge MCLK);
        rd = WB_DAT_O[7:0];
        {WB_CYC_I, WB_STB_I} <= 2'h0;
        @(posedge MCLK);
        if (i == 60)
        begin
            bad_count++;
            final_report();
        end
    endtask : wb
    task st(input logic [7:0] m, input logic [7:0] e);
        wb(1'h0, 4'h4, 8'h00);
        chk("status", e, rd & m);
    endtask : st
    // Frame strobe with parity, noise and stop-zero; lines show inverse values after it
    task frm(input logic [7:0] d, input logic [2:0] pnz);
        {RX_FRAME_DONE, RX_PARITY_BIT, RX_NOISE, RX_STOP_ZERO, RX_DATA} <= {1'h1, pnz, d};
        @(posedge MCLK);
        {RX_FRAME_DONE, RX_PARITY_BIT, RX_NOISE, RX_STOP_ZERO, RX_DATA} <= {1'h0, ~pnz, ~d};
        @(posedge MCLK);
    endtask : frm
    task ones(input int n, input logic v);
        repeat (n)
        begin
            {RX_BIT_TICK, RX_IN} <= {1'h1, v};
            @(posedge MCLK);
            RX_BIT_TICK <= 1'h0;
            @(posedge MCLK);
        end
    endtask : ones
    ////////////////////////////////////////////////////////////////////////////////
    task t_tx;
        st(8'hFF, 8'hC0);
        wb(1'h1, 4'h4, 8'h00);
        st(8'hFF, 8'hC0);
        wb(1'h0, 4'hC, 8'h00);
        chk("unmapped", 8'h00, rd);
        wb(1'h1, 4'h8, 8'h11);
        wb(1'h1, 4'h8, 8'h22);
        st(8'hC0, 8'h00);
        fork
            wb(1'h1, 4'h8, 8'h33);
            begin
                repeat (10) @(posedge MCLK);
                stall <= 1'h0;
            end
        join
        wt(1'h0);
        st(8'hC0, 8'h80);
        wt(1'h1);
        st(8'hC0, 8'hC0);
        TX_QUEUE <= 1'h1;
        // The status word is captured at the take edge, so let the queue strobe land first
        @(posedge MCLK);
        st(8'h40, 8'h00);
        chk("count", 8'h03, 8'(u_far.got.size()));
        chk("word 0", 8'h11, u_far.got[0]);
        chk("word 1", 8'h22, u_far.got[1]);
        chk("word 2", 8'h33, u_far.got[2]);
        $display("transmit test done");
    endtask : t_tx
    task t_rx;
        frm(8'h3C, 3'h0);
        st(8'h3F, 8'h20);
        wb(1'h0, 4'h8, 8'h00);
        chk("rx word", 8'h3C, rd);
        st(8'h3F, 8'h00);
        frm(8'hA1, 3'h0);
        frm(8'hB2, 3'h2);
        st(8'h3F, 8'h28);
        wb(1'h0, 4'h8, 8'h00);
        chk("kept word", 8'hA1, rd);
        st(8'h3F, 8'h00);
        frm(8'hC3, 3'h0);
        st(8'h3F, 8'h20);
        frm(8'hD4, 3'h0);
        wb(1'h0, 4'h8, 8'h00);
        st(8'h3F, 8'h08);
        wb(1'h0, 4'h8, 8'h00);
        st(8'h3F, 8'h00);
        wb(1'h1, 4'h0, 8'h01);
        frm(8'h01, 3'h3);
        st(8'h3F, 8'h27);
        frm(8'h55, 3'h4);
        st(8'h3F, 8'h27);
        chk("block", 8'h01, 8'(RX_BLOCK));
        wb(1'h0, 4'h8, 8'h00);
        st(8'h3F, 8'h00);
        chk("block", 8'h00, 8'(RX_BLOCK));
        wb(1'h1, 4'h0, 8'h03);
        frm(8'h01, 3'h0);
        st(8'h3F, 8'h20);
        wb(1'h0, 4'h8, 8'h00);
        $display("receive test done");
    endtask : t_rx
    task t_idle;
        wb(1'h1, 4'h0, 8'h00);
        ones(1, 1'h0);
        ones(9, 1'h1);
        st(8'h10, 8'h00);
        ones(1, 1'h1);
        st(8'h10, 8'h10);
        wb(1'h0, 4'h8, 8'h00);
        st(8'h10, 8'h00);
        ones(1, 1'h0);
        ones(10, 1'h1);
        st(8'h10, 8'h00);
        wb(1'h1, 4'h0, 8'h18);
        frm(8'h66, 3'h0);
        ones(1, 1'h0);
        ones(11, 1'h1);
        st(8'h30, 8'h20);
        chk("irq", 8'h00, 8'(RX_IRQ_REQ));
        RX_WAKE <= 1'h1;
        @(posedge MCLK);
        RX_WAKE <= 1'h0;
        repeat (3) @(posedge MCLK);
        chk("irq", 8'h01, 8'(RX_IRQ_REQ));
        wb(1'h1, 4'h0, 8'h00);
        chk("irq", 8'h00, 8'(RX_IRQ_REQ));
        wb(1'h1, 4'h0, 8'h04);
        ones(1, 1'h0);
        ones(10, 1'h1);
        st(8'h10, 8'h00);
        ones(1, 1'h1);
        st(8'h10, 8'h10);
        $display("idle test done");
    endtask : t_idle
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        MCLK = 1'h0;
        forever #25 MCLK = ~MCLK;
    end
    initial
    begin
        {SYS_RST, stall, TX_QUEUE, RX_IN} = 4'hD;
        {WB_CYC_I, WB_STB_I, WB_WE_I, WB_ADR_I, WB_SEL_I, WB_DAT_I} = {7'h00, 4'h1, 32'h0000_0000};
        {RX_FRAME_DONE, RX_PARITY_BIT, RX_NOISE, RX_STOP_ZERO, RX_BIT_TICK, RX_WAKE, RX_DATA} = 14'h0000;
        bad_count = 0;
        compares = 0;
        repeat (8) @(posedge MCLK);
        SYS_RST <= 1'h0;
        @(posedge MCLK);
        t_tx();
        t_rx();
        t_idle();
        final_report();
    end
endmodule : test_usf_status_flags
`default_nettype wire
